// ---- dct_defs.vh ----
// Constants for the DRAM command and strobe timing block.
// Assumes a 20 MHz system clock (50 ns) and a sampled link clock.
`ifndef DCT_DEFS_VH
`define DCT_DEFS_VH

// -----------------------------------------------------------------
// Clock rate
// -----------------------------------------------------------------
`define DCT_CLK_PS 32'd50000

// -----------------------------------------------------------------
// Printed times, in picoseconds
// -----------------------------------------------------------------
`define DCT_TAA_MIN_PS 32'd13750
`define DCT_TAA_MAX_PS 32'd20000
`define DCT_TRCD_PS 32'd13750
`define DCT_TRC_PS 32'd48750
`define DCT_TRAS_PS 32'd35000
`define DCT_TRP_PS 32'd13750
`define DCT_DLLOFF_PS 32'd8000

// -----------------------------------------------------------------
// Cycle counts; least times round up, longest round down, floor one
// -----------------------------------------------------------------
`define DCT_UP(t) (((t) + `DCT_CLK_PS - 32'd1) / `DCT_CLK_PS)
`define DCT_DN(t) (((t) / `DCT_CLK_PS) < 32'd1 ? 32'd1 : ((t) / `DCT_CLK_PS))

// -----------------------------------------------------------------
// Command codes on the command port
// -----------------------------------------------------------------
`define DCT_CMD_NOP 3'h0
`define DCT_CMD_ACT 3'h1
`define DCT_CMD_RD 3'h2
`define DCT_CMD_WR 3'h3
`define DCT_CMD_PRE 3'h4
`define DCT_CMD_REF 3'h5

// -----------------------------------------------------------------
// Geometry and latencies, in link clocks
// -----------------------------------------------------------------
`define DCT_BANKS 8
`define DCT_BANK_W 3
`define DCT_ADDR_W 6
`define DCT_DATA_W 16
`define DCT_BL 4'h8
`define DCT_RL 4'hb
`define DCT_WL 4'h8
`define DCT_DLLK 10'h200

`endif

// ---- dct_mem.v ----
// Small data array for the timing model, registered read port.
// Assumes one clock domain; write and read on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"

module dct_mem (
   input wire i_clock,
   input wire i_we,
   input wire [`DCT_ADDR_W-1:0] i_waddr,
   input wire [`DCT_DATA_W-1:0] i_wdata,
   input wire [`DCT_ADDR_W-1:0] i_raddr,
   output reg [`DCT_DATA_W-1:0] o_rdata
);
   reg [`DCT_DATA_W-1:0] mem [0:(1<<`DCT_ADDR_W)-1];

   // -----------------------------------------------------------------
   // Array access
   // -----------------------------------------------------------------
   // No reset on the array; read data is a register
   always @(posedge i_clock) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule // dct_mem
`default_nettype wire

// ---- dct_top.v ----
// Device side of the DRAM command timing and data strobe sequencing.
// Assumes commands arrive on link-clock rising edges, sampled at 20 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"

// Function
// R1 - First read data appears between 13.75 ns and 20 ns after read; here it comes RL link clocks (4400 ns) after read.
// R2 - Controller waits 13.75 ns from activate to read or write.
// R3 - Controller spaces activates or activate-refresh per bank by 48.75 ns.
// R4 - Row stays open 35 ns minimum, closed within nine refresh intervals.
// R5 - With loop off, controller keeps clock period at least 8 ns.
// R6 - Device drives read strobe preamble of at least 0.9 clocks.
// R7 - Device holds read strobe postamble of at least 0.3 clocks.
// R8 - Controller drives write strobe preamble of at least 0.9 clocks.
// R9 - Controller holds write strobe postamble of at least 0.3 clocks.
// R10 - Device enables strobe one clock before read latency expires.
// R11 - Device releases strobe at read latency plus half burst.
// R12 - Controller keeps write strobe within 0.27 clocks of clock edge.
// R13 - Controller waits 13.75 ns after precharge before activating.
// R14 - Controller allows 512 clocks for loop lock.
// R15 - Controller uses a permitted read and write latency pair.
module dct_top (
   input wire i_clock,
   input wire i_rst,
   input wire i_link_clk,
   input wire [2:0] i_cmd,
   input wire [`DCT_BANK_W-1:0] i_bank,
   input wire [`DCT_ADDR_W-1:0] i_addr,
   input wire [`DCT_DATA_W-1:0] i_dq,
   input wire i_dqs,
   output reg [`DCT_DATA_W-1:0] o_dq,
   output reg o_dq_oe,
   output reg o_dqs,
   output reg o_dqs_oe,
   output reg o_viol
);
   localparam [31:0] TAA_CYC = `DCT_UP(`DCT_TAA_MIN_PS);
   localparam [31:0] TRCD_CYC = `DCT_UP(`DCT_TRCD_PS);
   localparam [31:0] TRC_CYC = `DCT_UP(`DCT_TRC_PS);
   localparam [31:0] TRAS_CYC = `DCT_UP(`DCT_TRAS_PS);
   localparam [31:0] TRP_CYC = `DCT_UP(`DCT_TRP_PS);
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_WAIT = 2'h1;
   localparam [1:0] S_PRE = 2'h2;
   localparam [1:0] S_BURST = 2'h3;

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   reg [2:0] lck_q;
   reg [2:0] cmd_s1_q, cmd_s2_q;
   reg [`DCT_BANK_W-1:0] bank_s1_q, bank_s2_q;
   reg [`DCT_ADDR_W-1:0] addr_s1_q, addr_s2_q;
   reg [`DCT_DATA_W-1:0] dq_s1_q, dq_s2_q;
   reg dqs_s1_q, dqs_s2_q, dqs_s3_q;
   wire lck_rise = lck_q[1] & ~lck_q[2];
   wire lck_fall = ~lck_q[1] & lck_q[2];
   wire dqs_rise = dqs_s2_q & ~dqs_s3_q;

   // Two flops on every pin; third stage only for edge finding
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         lck_q <= 3'h0;
         cmd_s1_q <= `DCT_CMD_NOP;
         cmd_s2_q <= `DCT_CMD_NOP;
         bank_s1_q <= {`DCT_BANK_W{1'b0}};
         bank_s2_q <= {`DCT_BANK_W{1'b0}};
         addr_s1_q <= {`DCT_ADDR_W{1'b0}};
         addr_s2_q <= {`DCT_ADDR_W{1'b0}};
         dq_s1_q <= {`DCT_DATA_W{1'b0}};
         dq_s2_q <= {`DCT_DATA_W{1'b0}};
         dqs_s1_q <= 1'b0;
         dqs_s2_q <= 1'b0;
         dqs_s3_q <= 1'b0;
      end else begin
         lck_q <= {lck_q[1:0], i_link_clk};
         cmd_s1_q <= i_cmd;
         cmd_s2_q <= cmd_s1_q;
         bank_s1_q <= i_bank;
         bank_s2_q <= bank_s1_q;
         addr_s1_q <= i_addr;
         addr_s2_q <= addr_s1_q;
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
         dqs_s1_q <= i_dqs;
         dqs_s2_q <= dqs_s1_q;
         dqs_s3_q <= dqs_s2_q;
      end
   end

   // -----------------------------------------------------------------
   // Per-bank timers and controller-side checks
   // -----------------------------------------------------------------
   wire cmd_act = lck_rise && (cmd_s2_q == `DCT_CMD_ACT);
   wire cmd_rd = lck_rise && (cmd_s2_q == `DCT_CMD_RD);
   wire cmd_wr = lck_rise && (cmd_s2_q == `DCT_CMD_WR);
   wire cmd_pre = lck_rise && (cmd_s2_q == `DCT_CMD_PRE);
   wire cmd_ref = lck_rise && (cmd_s2_q == `DCT_CMD_REF);
   wire [`DCT_BANKS-1:0] bank_err;
   genvar g;
   generate
      for (g = 0; g < `DCT_BANKS; g = g + 1) begin : g_bank
         reg [7:0] act_age_q;
         reg [7:0] pre_age_q;
         reg open_q;
         wire sel = (bank_s2_q == g);
         // Ages saturate so a long idle never wraps into a false error
         always @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
               act_age_q <= 8'hff;
               pre_age_q <= 8'hff;
               open_q <= 1'b0;
            end else begin
               if (cmd_act && sel) begin
                  act_age_q <= 8'h00;
                  open_q <= 1'b1;
               end else if (act_age_q != 8'hff) begin
                  act_age_q <= act_age_q + 8'h01;
               end
               if (cmd_pre && sel) begin
                  pre_age_q <= 8'h00;
                  open_q <= 1'b0;
               end else if (pre_age_q != 8'hff) begin
                  pre_age_q <= pre_age_q + 8'h01;
               end
            end
         end
         assign bank_err[g] = sel && (
            ((cmd_rd || cmd_wr) && act_age_q < TRCD_CYC) ||             // R2
            ((cmd_act || cmd_ref) && act_age_q < TRC_CYC) ||            // R3
            (cmd_pre && open_q && act_age_q < TRAS_CYC) ||              // R4
            (cmd_act && pre_age_q < TRP_CYC));                          // R13
      end
   endgenerate

   // Sticky error flag, cleared only by reset
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_viol <= 1'b0;
      end else if (|bank_err) begin
         o_viol <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Write capture on strobe rising edges
   // -----------------------------------------------------------------
   reg [`DCT_ADDR_W-1:0] wptr_q;
   reg [3:0] wcnt_q;

   // Eight beats sampled per burst; falling edges skipped, a trade-off
   // of the 20 MHz sampler which cannot see both edges of a fast strobe
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wptr_q <= {`DCT_ADDR_W{1'b0}};
         wcnt_q <= 4'h0;
      end else if (cmd_wr) begin
         wptr_q <= addr_s2_q;
         wcnt_q <= `DCT_BL;
      end else if (dqs_rise && wcnt_q != 4'h0) begin
         wptr_q <= wptr_q + {{(`DCT_ADDR_W-1){1'b0}}, 1'b1};
         wcnt_q <= wcnt_q - 4'h1;
      end
   end

   // -----------------------------------------------------------------
   // Read sequencer, counted in link clocks
   // -----------------------------------------------------------------
   reg [1:0] st_q;
   reg [3:0] lat_q;
   reg [3:0] beat_q;
   reg [3:0] age_q;
   reg [`DCT_ADDR_W-1:0] rptr_q;
   wire [`DCT_DATA_W-1:0] rdata;

   dct_mem u_mem (
      .i_clock(i_clock),
      .i_we(dqs_rise && wcnt_q != 4'h0),
      .i_waddr(wptr_q),
      .i_wdata(dq_s2_q),
      .i_raddr(rptr_q),
      .o_rdata(rdata)
   );

   // Latency counts link edges; data waits at least the access time
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_q <= S_IDLE;
         lat_q <= 4'h0;
         beat_q <= 4'h0;
         age_q <= 4'h0;
         rptr_q <= {`DCT_ADDR_W{1'b0}};
         o_dqs_oe <= 1'b0;
         o_dqs <= 1'b0;
         o_dq_oe <= 1'b0;
         o_dq <= {`DCT_DATA_W{1'b0}};
      end else begin
         if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
         end
         case (st_q)
            S_IDLE: begin
               if (cmd_rd) begin
                  st_q <= S_WAIT;
                  lat_q <= `DCT_RL - 4'h1;
                  age_q <= 4'h0;
                  rptr_q <= addr_s2_q;
               end
            end
            S_WAIT: begin
               if (lck_rise) begin
                  lat_q <= lat_q - 4'h1;
                  if (lat_q == 4'h1) begin
                     st_q <= S_PRE;
                     o_dqs_oe <= 1'b1;                                  // R10
                     o_dqs <= 1'b0;                                     // R6
                  end
               end
            end
            S_PRE: begin
               // Whole-clock low preamble exceeds 0.9 clocks
               if (lck_rise && age_q >= TAA_CYC) begin                 // R1
                  st_q <= S_BURST;
                  beat_q <= `DCT_BL;
                  o_dq_oe <= 1'b1;
                  o_dq <= rdata;
                  o_dqs <= 1'b1;                                        // R6
                  rptr_q <= rptr_q + {{(`DCT_ADDR_W-1){1'b0}}, 1'b1};
               end
            end
            S_BURST: begin
               if (lck_rise || lck_fall) begin
                  beat_q <= beat_q - 4'h1;
                  if (beat_q == 4'h1) begin
                     // RL plus BL/2: the last low half was the postamble, so let go
                     st_q <= S_IDLE;
                     o_dq_oe <= 1'b0;
                     o_dqs <= 1'b0;                                     // R7
                     o_dqs_oe <= 1'b0;                                  // R11
                  end else begin
                     o_dq <= rdata;
                     o_dqs <= ~o_dqs;
                     rptr_q <= rptr_q + {{(`DCT_ADDR_W-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // dct_top
`default_nettype wire

// ---- dct_top_assertions.sv ----
// Checker for the read strobe and read data sequencing of dct_top.
// Assumes the 400 ns link clock is sampled by the 50 ns system clock.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"
module dct_top_chk (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [`DCT_DATA_W-1:0] o_dq,
   input wire logic o_dq_oe,
   input wire logic o_dqs,
   input wire logic o_dqs_oe
);
   logic [5:0] hi_q;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // -------------------------------------------------------------
   // Burst length counter
   // -------------------------------------------------------------
   // Counts driven cycles, so a beat lost or added shows at burst end
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) hi_q <= 6'h00;
      else hi_q <= o_dq_oe ? hi_q + 6'h01 : 6'h00;
   end
   // Strobe driven low with no data before the burst, and with data in each low half of the burst
   sequence s_preamble;
      (o_dqs_oe && !o_dqs && !o_dq_oe) [*7];
   endsequence
   sequence s_postamble;
      (o_dqs_oe && !o_dqs && o_dq_oe) [*4];
   endsequence
   a_pre_low: assert property ($rose(o_dqs_oe) |-> s_preamble)
      else $error("read preamble too short");
   a_first_beat: assert property ($rose(o_dqs_oe) |-> ##[7:9] ($rose(o_dq_oe) && o_dqs))
      else $error("first beat not one link clock after strobe enable");
   a_beat_width: assert property ($rose(o_dq_oe) |-> o_dqs [*4] ##1 !o_dqs [*4])
      else $error("read strobe does not follow link edges");
   a_beat_stable: assert property (o_dq_oe && $past(o_dq_oe) && $changed(o_dq)
      |=> $stable(o_dq) [*3])
      else $error("read word changed inside a beat");
   a_burst_len: assert property ($fell(o_dq_oe) |-> hi_q == 6'd32)
      else $error("read burst not eight beats long");
   a_post_hold: assert property ($fell(o_dqs) && o_dqs_oe |-> s_postamble)
      else $error("read strobe low half too short");
   a_strobe_release: assert property ($fell(o_dq_oe) |-> $fell(o_dqs_oe))
      else $error("strobe not released with the end of the burst");
   a_oe_pair: assert property (o_dq_oe |-> o_dqs_oe)
      else $error("data driven without strobe");
endmodule // dct_top_chk
bind dct_top dct_top_chk chk_u (.i_clock(i_clock), .i_rst(i_rst), .o_dq(o_dq),
   .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe));
`default_nettype wire

// ---- dct_ctrl_model.sv ----
// Memory controller model: command clock, commands and write bursts.
// Assumes the bench calls its tasks one after another, never overlapping.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"
module dct_ctrl_model (
   output logic o_link_clk,
   output logic [2:0] o_cmd,
   output logic [`DCT_BANK_W-1:0] o_bank,
   output logic [`DCT_ADDR_W-1:0] o_addr,
   output logic [`DCT_DATA_W-1:0] o_dq,
   output logic o_dqs
);
   realtime t_take;
   // Command clock runs free, offset so its edges never meet the system clock
   initial begin
      o_link_clk = 1'b0;
      o_cmd = `DCT_CMD_NOP;
      o_bank = 3'h0;
      o_addr = 6'h00;
      o_dq = 16'hffff;
      o_dqs = 1'b1;
      #13;
      forever #200 o_link_clk = ~o_link_clk;
   end
   // -------------------------------------------------------------
   // Command and write tasks
   // -------------------------------------------------------------
   task automatic lock_wait;
      repeat (`DCT_DLLK) @(posedge o_link_clk);
   endtask
   // Calls sit 800 ns apart, far beyond every row spacing at this rate
   task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [5:0] a);
      @(negedge o_link_clk);
      o_cmd = c;
      o_bank = b;
      o_addr = a;
      @(posedge o_link_clk);
      t_take = $realtime;
      @(negedge o_link_clk);
      o_cmd = `DCT_CMD_NOP;
   endtask
   // Strobe rises on link rises; data moves at falls, away from the strobe, until the closing rise flips it
   task automatic write(input logic [2:0] b, input logic [5:0] a, input logic [15:0] base);
      integer n;
      send(`DCT_CMD_WR, b, a);
      repeat (`DCT_WL - 2) @(negedge o_link_clk);
      o_dqs = 1'b0;
      o_dq = base;
      @(posedge o_link_clk);
      for (n = 1; n <= 8; n++) begin
         @(posedge o_link_clk);
         o_dqs = 1'b1;
         @(negedge o_link_clk);
         o_dqs = 1'b0;
         o_dq = base + 16'(n);
      end
      @(posedge o_link_clk);
      o_dqs = 1'b1;
      o_dq = ~o_dq;
   endtask
endmodule // dct_ctrl_model
`default_nettype wire

// ---- dct_top_tb.sv ----
// Self-checking bench for dct_top with a controller model on its far side.
// Assumes the model's tasks are called one at a time from here.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.vh"
module dct_top_tb;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   wire link;
   wire [2:0] cmd;
   wire [2:0] bank;
   wire [5:0] addr;
   wire [15:0] wdq;
   wire wdqs;
   wire [15:0] o_dq;
   wire o_dq_oe;
   wire o_dqs;
   wire o_dqs_oe;
   wire o_viol;
   integer n_mismatch = 0;
   integer checks_done = 0;
   integer cyc = 0;
   always #25 i_clock = ~i_clock;
   dct_ctrl_model ctrl_u (.o_link_clk(link), .o_cmd(cmd), .o_bank(bank), .o_addr(addr),
      .o_dq(wdq), .o_dqs(wdqs));
   dct_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_link_clk(link), .i_cmd(cmd),
      .i_bank(bank), .i_addr(addr), .i_dq(wdq), .i_dqs(wdqs), .o_dq(o_dq),
      .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .o_viol(o_viol));
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_mismatch = n_mismatch + 1;
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Reads a burst and checks latency, beats, postamble and release
   task rd_check(input logic [2:0] b, input logic [5:0] a, input logic [15:0] base);
      integer w;
      integer n;
      realtime lat;
      w = 0;
      ctrl_u.send(`DCT_CMD_RD, b, a);
      while (o_dq_oe !== 1'b1 && w < 200) begin
         @(negedge i_clock);
         w = w + 1;
      end
      lat = $realtime - ctrl_u.t_take;
      chk({15'h0000, (lat >= 4400.0) && (lat <= 4600.0)}, 16'h0001);
      for (n = 0; n < 8; n++) begin
         chk(o_dq, base + 16'(n));
         chk({15'h0000, o_dqs}, {15'h0000, ~n[0]});
         chk({14'h0000, o_dqs_oe, o_dq_oe}, 16'h0003);
         repeat (4) @(negedge i_clock);
      end
      chk({13'h0000, o_dq_oe, o_dqs, o_dqs_oe}, 16'h0000);
      repeat (8) @(negedge i_clock);
      chk({13'h0000, o_dq_oe, o_dqs, o_dqs_oe}, 16'h0000);
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task t_write_read;
      ctrl_u.send(`DCT_CMD_ACT, 3'h0, 6'h00);
      ctrl_u.write(3'h0, 6'h08, 16'h1200);
      rd_check(3'h0, 6'h08, 16'h1200);
      chk({15'h0000, o_viol}, 16'h0000);
      $display("t_write_read done");
   endtask
   // A read landing inside a burst must not start a second one
   task t_read_refused;
      logic seen;
      seen = 1'b0;
      fork
         rd_check(3'h0, 6'h08, 16'h1200);
         begin
            repeat (13) @(negedge link);
            ctrl_u.send(`DCT_CMD_RD, 3'h0, 6'h10);
         end
      join
      repeat (120) begin
         @(negedge i_clock);
         if (o_dqs_oe === 1'b1) seen = 1'b1;
      end
      chk({15'h0000, seen}, 16'h0000);
      $display("t_read_refused done");
   endtask
   // Close, refresh, open the last bank and burst up to the top address
   task t_bank_cycle;
      ctrl_u.send(`DCT_CMD_PRE, 3'h0, 6'h00);
      ctrl_u.send(`DCT_CMD_REF, 3'h0, 6'h00);
      ctrl_u.send(`DCT_CMD_ACT, 3'h7, 6'h00);
      ctrl_u.write(3'h7, 6'h38, 16'hbee0);
      rd_check(3'h7, 6'h38, 16'hbee0);
      chk({15'h0000, o_viol}, 16'h0000);
      $display("t_bank_cycle done");
   endtask
   // Hang guard: lock wait is about 4100 cycles, the tests under 1500
   always @(posedge i_clock) begin
      cyc = cyc + 1;
      if (cyc == 10000) begin
         n_mismatch = n_mismatch + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (16) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      ctrl_u.lock_wait;
      t_write_read;
      t_read_refused;
      t_bank_cycle;
      wrap_up;
   end
endmodule // dct_top_tb
`default_nettype wire
